// ### hw/pon_top.sv
module pon_top
  import pon_pkg::*;
#(
  parameter int CH = NUM_CH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [CH-1:0] cmp_match_a,
  output logic [7:0] port_a_pins,
  output logic [7:0] port_b_pins,
  output logic [7:0] port_a_enable,
  output logic [7:0] port_b_enable
);

  pon_ctrl_t ctrl;
  pon_ctrl_t next_ctrl;
  logic [15:0] staged;
  logic [15:0] next_staged;
  pon_dphase_t dphase;
  pon_dphase_t next_dphase;
  logic [31:0] next_hrdata;
  logic [15:0] pattern_outputs;

  // address phase
  wire logic addr_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  wire logic word_ok = (haddr[1:0] == 2'h0) && (hsize == 3'h2);
  wire logic [IDX_W-1:0] addr_idx = haddr[ADDR_W-1:2];

  assign next_dphase.valid = addr_take && word_ok;
  assign next_dphase.write = hwrite;
  assign next_dphase.idx = addr_idx;

  // data phase write decode
  wire logic wr = dphase.valid && dphase.write;
  wire logic [7:0] wbyte = hwdata[7:0];
  wire logic wr_sel = wr && (dphase.idx == IDX_TRIG_SELECT);
  wire logic wr_uen = wr && (dphase.idx == IDX_UPPER_OUTPUT_ENABLE);
  wire logic wr_len = wr && (dphase.idx == IDX_LOWER_OUTPUT_ENABLE);
  wire logic wr_und = wr && (dphase.idx == IDX_UPPER_NEXT_DATA);
  wire logic wr_lnd = wr && (dphase.idx == IDX_LOWER_NEXT_DATA);
  wire logic wr_una = wr && (dphase.idx == IDX_UPPER_NEXT_DATA_ALT);
  wire logic wr_lna = wr && (dphase.idx == IDX_LOWER_NEXT_DATA_ALT);

  // group trigger fields
  wire logic [1:0] grp3_sel = ctrl.sel[GRP3_SEL_LSB +: 2];
  wire logic [1:0] grp2_sel = ctrl.sel[GRP2_SEL_LSB +: 2];
  wire logic [1:0] grp1_sel = ctrl.sel[GRP1_SEL_LSB +: 2];
  wire logic [1:0] grp0_sel = ctrl.sel[GRP0_SEL_LSB +: 2];
  wire logic upper_shared = (grp3_sel == grp2_sel);
  wire logic lower_shared = (grp1_sel == grp0_sel);

  // control registers
  assign next_ctrl.sel = wr_sel ? wbyte : ctrl.sel;
  assign next_ctrl.upper_en = wr_uen ? wbyte : ctrl.upper_en;
  assign next_ctrl.lower_en = wr_len ? wbyte : ctrl.lower_en;

  // staged data, layout follows trigger sharing
  wire logic wr_s15_12 = wr_und;
  wire logic wr_s11_8 = upper_shared ? wr_und : wr_una;
  wire logic wr_s7_4 = wr_lnd;
  wire logic wr_s3_0 = lower_shared ? wr_lnd : wr_lna;
  wire logic [3:0] src_11_8 = upper_shared ? wbyte[7:4] : wbyte[3:0];
  wire logic [3:0] src_3_0 = lower_shared ? wbyte[7:4] : wbyte[3:0];

  assign next_staged[15:12] = wr_s15_12 ? wbyte[7:4] : staged[15:12];
  assign next_staged[11:8] = wr_s11_8 ? (upper_shared ? wbyte[3:0] : src_11_8)
                                      : staged[11:8];
  assign next_staged[7:4] = wr_s7_4 ? wbyte[7:4] : staged[7:4];
  assign next_staged[3:0] = wr_s3_0 ? (lower_shared ? wbyte[3:0] : src_3_0)
                                    : staged[3:0];

  // read views, built from next values so a read right after a write sees it
  wire logic nxt_upper_shared = next_ctrl.sel[GRP3_SEL_LSB +: 2]
                                == next_ctrl.sel[GRP2_SEL_LSB +: 2];
  wire logic nxt_lower_shared = next_ctrl.sel[GRP1_SEL_LSB +: 2]
                                == next_ctrl.sel[GRP0_SEL_LSB +: 2];
  wire logic [7:0] rd_und = nxt_upper_shared ? next_staged[15:8]
                                              : {next_staged[15:12], UNUSED_NIBBLE};
  wire logic [7:0] rd_una = nxt_upper_shared ? UNUSED_BYTE
                                              : {UNUSED_NIBBLE, next_staged[11:8]};
  wire logic [7:0] rd_lnd = nxt_lower_shared ? next_staged[7:0]
                                              : {next_staged[7:4], UNUSED_NIBBLE};
  wire logic [7:0] rd_lna = nxt_lower_shared ? UNUSED_BYTE
                                              : {UNUSED_NIBBLE, next_staged[3:0]};

  logic [7:0] rd_byte;
  always_comb begin
    unique case (addr_idx)
      IDX_TRIG_SELECT: rd_byte = next_ctrl.sel;
      IDX_UPPER_OUTPUT_ENABLE: rd_byte = next_ctrl.upper_en;
      IDX_LOWER_OUTPUT_ENABLE: rd_byte = next_ctrl.lower_en;
      IDX_UPPER_NEXT_DATA: rd_byte = rd_und;
      IDX_LOWER_NEXT_DATA: rd_byte = rd_lnd;
      IDX_UPPER_NEXT_DATA_ALT: rd_byte = rd_una;
      IDX_LOWER_NEXT_DATA_ALT: rd_byte = rd_lna;
      default: rd_byte = 8'h00;
    endcase
  end

  wire logic rd_take = addr_take && word_ok && !hwrite;
  assign next_hrdata = rd_take ? {24'h000000, rd_byte} : 32'h00000000;

  // bus and register flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dphase <= '0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      dphase <= next_dphase;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl.sel <= RST_TRIG_SELECT;
      ctrl.upper_en <= RST_OUTPUT_ENABLE;
      ctrl.lower_en <= RST_OUTPUT_ENABLE;
      staged <= RST_STAGED;
    end else begin
      ctrl <= next_ctrl;
      staged <= next_staged;
    end
  end

  // per-group transfer on compare match A
  wire logic [15:0] enables = {ctrl.upper_en, ctrl.lower_en};

  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g++) begin : g_grp
      pon_group #(
        .W(GRP_W),
        .CH(CH)
      ) u_grp (
        .clk(clk),
        .rst(rst),
        .trig_sel(ctrl.sel[2*g +: 2]),
        .cmp_match_a(cmp_match_a),
        .enable(enables[GRP_W*g +: GRP_W]),
        .staged(staged[GRP_W*g +: GRP_W]),
        .pattern_out(pattern_outputs[GRP_W*g +: GRP_W])
      );
    end
  endgenerate

  // pins: enabled bits drive the port, disabled bits are released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_a_enable <= RST_OUTPUT_ENABLE;
      port_b_enable <= RST_OUTPUT_ENABLE;
    end else begin
      port_a_enable <= next_ctrl.lower_en;
      port_b_enable <= next_ctrl.upper_en;
    end
  end

  // pattern flops live in the groups; the pin copies track them one clock later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_a_pins <= RST_PATTERN[7:0];
      port_b_pins <= RST_PATTERN[15:8];
    end else begin
      port_a_pins <= pattern_outputs[7:0];
      port_b_pins <= pattern_outputs[15:8];
    end
  end

endmodule

// ### hw/pon_pkg.sv
package pon_pkg;

  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;
  localparam int NUM_GRP = 4;
  localparam int GRP_W = 4;
  localparam int NUM_CH = 4;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TRIG_SELECT = 16'h00a1;
  localparam logic [IDX_W-1:0] IDX_UPPER_OUTPUT_ENABLE = 16'h00a2;
  localparam logic [IDX_W-1:0] IDX_LOWER_OUTPUT_ENABLE = 16'h00a3;
  localparam logic [IDX_W-1:0] IDX_UPPER_NEXT_DATA = 16'hffa4;
  localparam logic [IDX_W-1:0] IDX_LOWER_NEXT_DATA = 16'hffa5;
  localparam logic [IDX_W-1:0] IDX_UPPER_NEXT_DATA_ALT = 16'hffa6;
  localparam logic [IDX_W-1:0] IDX_LOWER_NEXT_DATA_ALT = 16'hffa7;

  // field positions in the trigger select register
  localparam int GRP3_SEL_LSB = 6;
  localparam int GRP2_SEL_LSB = 4;
  localparam int GRP1_SEL_LSB = 2;
  localparam int GRP0_SEL_LSB = 0;

  // values after reset, and fill values for unused staged-data read bits
  localparam logic [7:0] RST_TRIG_SELECT = 8'hff;
  localparam logic [7:0] RST_OUTPUT_ENABLE = 8'h00;
  localparam logic [15:0] RST_STAGED = 16'h0000;
  localparam logic [15:0] RST_PATTERN = 16'h0000;
  localparam logic [3:0] UNUSED_NIBBLE = 4'hf;
  localparam logic [7:0] UNUSED_BYTE = 8'hff;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef struct packed {
    logic valid;
    logic write;
    logic [IDX_W-1:0] idx;
  } pon_dphase_t;

  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] upper_en;
    logic [7:0] lower_en;
  } pon_ctrl_t;

endpackage

// ### hw/pon_group.sv
module pon_group
  import pon_pkg::*;
#(
  parameter int W = GRP_W,
  parameter int CH = NUM_CH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] trig_sel,
  input wire logic [CH-1:0] cmp_match_a,
  input wire logic [W-1:0] enable,
  input wire logic [W-1:0] staged,
  output logic [W-1:0] pattern_out
);

  wire logic fire = cmp_match_a[trig_sel];
  logic [W-1:0] next_pattern_out;

  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      // disabled bits keep their value whatever the trigger does
      assign next_pattern_out[b] = (fire && enable[b]) ? staged[b] : pattern_out[b];
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pattern_out <= '0;
    end else begin
      pattern_out <= next_pattern_out;
    end
  end

endmodule

// ### testbench/pon_timer_model.sv
module pon_timer_model
  import pon_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [1:0] ch,
  input wire logic [2:0] delay,
  output logic [NUM_CH-1:0] cmp_match_a
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pend;
  logic [2:0] cnt;
  logic [1:0] sel;
  // one-cycle compare match pulse, delay plus one cycles after the clock edge that samples the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
      cnt <= 3'h0;
      sel <= 2'h0;
      cmp_match_a <= '0;
    end else begin
      cmp_match_a <= '0;
      if (go) begin
        pend <= 1'b1;
        cnt <= delay;
        sel <= ch;
      end else if (pend && cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end else if (pend) begin
        pend <= 1'b0;
        cmp_match_a[sel] <= 1'b1;
      end
    end
  end
endmodule

// ### testbench/pon_properties.sv
module pon_properties
  import pon_pkg::*;
#(
  parameter int CH = NUM_CH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [CH-1:0] cmp_match_a,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] port_a_enable,
  input wire logic [7:0] port_b_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic take = hsel && hready && htrans[1] && hsize == 3'h2;
  wire logic rd = take && !hwrite;
  wire logic wr = take && hwrite;
  wire logic trig = |cmp_match_a;
  wire logic [15:0] pins = {port_b_pins, port_a_pins};
  wire logic [15:0] ens = {port_b_enable, port_a_enable};
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_ready_after_rst: assert property (!$past(rst) |-> hreadyout) else $error("hreadyout low");
  a_rdata_idle: assert property (!$past(rd) |-> hrdata == 32'h0) else $error("hrdata not idle");
  a_alt_ones:
    assert property (rd && haddr[17:3] == 15'h7fd3 |=> hrdata[7:4] == 4'hf)
      else $error("alt high bits not ones");
  a_lower_enable:
    assert property (wr && haddr == 18'h0028c ##1 1'b1 |=> port_a_enable == $past(hwdata[7:0]))
      else $error("port a enable wrong");
  a_upper_enable:
    assert property (wr && haddr == 18'h00288 ##1 1'b1 |=> port_b_enable == $past(hwdata[7:0]))
      else $error("port b enable wrong");
  a_disabled_hold:
    assert property (((pins ^ $past(pins)) & ~$past(ens, 2)) == 16'h0)
      else $error("disabled pin moved");
  a_pins_need_trig:
    assert property (pins != $past(pins) |-> $past(trig, 2)) else $error("pins moved untriggered");
  c_alt_read: cover property (rd && haddr[17:3] == 15'h7fd3);
  c_trigger: cover property (trig);
  c_pins_move: cover property (pins != $past(pins));
endmodule

bind pon_top pon_properties #(.CH(CH)) u_props (
  .clk(clk),
  .rst(rst),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsize(hsize),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .cmp_match_a(cmp_match_a),
  .port_a_pins(port_a_pins),
  .port_b_pins(port_b_pins),
  .port_a_enable(port_a_enable),
  .port_b_enable(port_b_enable)
);

// ### testbench/pattern_output_next_data_bench.sv
module pattern_output_next_data_bench
  import pon_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic [ADDR_W-1:0] haddr = '0;
  logic [1:0] htrans = 2'h0, ch = 2'h0;
  logic [2:0] hsize = 3'h2, delay = 3'h0;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic hreadyout, hresp;
  logic [NUM_CH-1:0] cmp_match_a;
  logic [7:0] port_a_pins, port_b_pins, port_a_enable, port_b_enable;
  // select, upper enable, lower enable, upper staged, lower staged
  logic [7:0] m [5] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] mp = 16'h0;
  logic [15:0] regs [8] = '{IDX_TRIG_SELECT, IDX_UPPER_OUTPUT_ENABLE, IDX_LOWER_OUTPUT_ENABLE,
    IDX_UPPER_NEXT_DATA, IDX_LOWER_NEXT_DATA, IDX_UPPER_NEXT_DATA_ALT,
    IDX_LOWER_NEXT_DATA_ALT, 16'h0123};
  int errors = 0, tests_run = 0, cyc = 0;
  pon_top DUT (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .cmp_match_a(cmp_match_a),
    .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins),
    .port_a_enable(port_a_enable),
    .port_b_enable(port_b_enable)
  );
  pon_timer_model u_timer (
    .clk(clk),
    .rst(rst),
    .go(go),
    .ch(ch),
    .delay(delay),
    .cmp_match_a(cmp_match_a)
  );
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("counts: tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // bits owned by a staged-data address in the current layout
  function automatic logic [7:0] msk(input logic [15:0] i);
    logic s;
    s = i[0] ? m[0][3:2] == m[0][1:0] : m[0][7:6] == m[0][5:4];
    return s ? (i[1] ? 8'h00 : 8'hff) : (i[1] ? 8'h0f : 8'hf0);
  endfunction
  task automatic acc(input int k, input bit w, input logic [7:0] d);
    logic [7:0] mk;
    int b;
    mk = msk(regs[k]);
    b = k < 3 ? k : 3 + int'(regs[k][0]);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {regs[k], 2'b00};
    hwrite <= w;
    do @(posedge clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (!hreadyout);
    if (!w && k == 7) chk("unmapped", 32'h0, hrdata);
    if (!w && k < 3) chk("control", {24'h0, m[b]}, hrdata);
    if (!w && k > 2 && k < 7) chk("staged", {24'h0, (m[b] & mk) | ~mk}, hrdata);
    if (w && k < 3) m[b] = d;
    if (w && k > 2 && k < 7) m[b] = (m[b] & ~mk) | (d & mk);
  endtask
  task automatic trig(input logic [1:0] c, input logic [2:0] dl);
    logic [15:0] gm;
    int k;
    gm = 16'h0;
    go <= 1'b1;
    ch <= c;
    delay <= dl;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 12 && cmp_match_a == '0; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    for (int g = 0; g < 4; g++) if (m[0][2*g+:2] == c) gm[4*g+:4] = 4'hf;
    gm = gm & {m[1], m[2]};
    mp = ({m[3], m[4]} & gm) | (mp & ~gm);
    chk("pins", {m[1], m[2], mp}, {port_b_enable, port_a_enable, port_b_pins, port_a_pins});
  endtask
  initial begin
    void'($urandom(71));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 8; k++) acc(k, 1'b0, 8'h00);
    $display("test reset_values done");
    repeat (150) begin
      acc($urandom % 8, 1'b1, 8'($urandom));
      acc($urandom % 8, 1'b0, 8'h00);
      trig(2'($urandom), 3'($urandom));
    end
    $display("test random_traffic done");
    summarize();
  end
endmodule
